// ==== logic/smbus_front_map.svh ====
`ifndef SMBUS_FRONT_MAP_SVH
`define SMBUS_FRONT_MAP_SVH

// System clock period, in nanoseconds
`define SYS_PERIOD_NS 50
// Quiet period after power-up, in nanoseconds (5.5 ms)
`define QUIET_TIME_NS 5500000
// Time from the waking read to full function, in nanoseconds (3 ms)
`define WAKE_TIME_NS 3000000

// Timer width, wide enough for the quiet count
`define TMR_W 17
// Timer value at which the settled strap is latched
`define STRAP_LATCH_CYC 17'h00003

// Strap code: top bit picks the mode, low bits the limit step
`define STRAP_W 4
`define STRAP_MODE_BIT 3
`define STRAP_STEP_W 3

// Current limit field width and the eight steps, in mA
`define LIMIT_W 12
`define LIM_500 12'h1f4
`define LIM_900 12'h384
`define LIM_1000 12'h3e8
`define LIM_1200 12'h4b0
`define LIM_1500 12'h5dc
`define LIM_1800 12'h708
`define LIM_2000 12'h7d0
`define LIM_2500 12'h9c4

// Address byte layout: seven address bits, direction in bit 0
`define ADDR_W 7
// Width of one bus byte, and the lowest address bit in it
`define BYTE_W 8
`define ADDR_LSB 1
`define RW_BIT 0
`define RW_READ 1'b1
// Width of the address byte bit counter, and the last bit index
`define BIT_CNT_W 4
`define LAST_BIT 4'h7

`endif

// ==== logic/smbus_front_pkg.sv ====
`include "smbus_front_map.svh"

package smbus_front_pkg;

  // Top-level sequencing, one-hot
  typedef enum logic [2:0]
  {
    ST_QUIET = 3'b001,  // Power-up quiet period
    ST_RUN   = 3'b010,  // Normal operation
    ST_WAKE  = 3'b100   // Waking from Sleep
  } front_state_t;

  // Communication mode picked by the strap
  typedef enum logic
  {
    MODE_SERIAL     = 1'b0,
    MODE_STANDALONE = 1'b1
  } comm_mode_t;

  // Latched strap result
  typedef struct packed
  {
    comm_mode_t              mode;   // Serial or stand-alone
    logic [`LIMIT_W-1:0]     limit;  // Hardware current limit in mA
  } strap_cfg_t;

  // First byte of a frame
  typedef struct packed
  {
    logic [`ADDR_W-1:0] addr;  // Seven-bit client address
    logic               rw;    // 1 = host read, 0 = host write
  } addr_byte_t;

endpackage

// ==== logic/smbus_mode_select_front.sv ====
// How it works
// - Strap code gives mode and current limit
// - Low strap codes select serial client mode
// - High strap codes select stand-alone mode
// - Ignore bus traffic for 5.5 ms after power-up
// - First read to our address wakes Sleep
// - Waking access data flagged for discard
// - Fully working 3 ms after the waking read
// - Never hold the serial clock low
// - Start is data falling while clock high
// - First byte: seven address bits, then direction
`timescale 1ns/10ps
`include "smbus_front_map.svh"

module smbus_mode_select_front
  import smbus_front_pkg::*;
#(
  // Quiet period in cycles, rounded up
  parameter logic [`TMR_W-1:0] QUIET_CYC =
    `TMR_W'((`QUIET_TIME_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS),
  // Wake time in cycles, rounded up
  parameter logic [`TMR_W-1:0] WAKE_CYC =
    `TMR_W'((`WAKE_TIME_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
)
(
  input  wire logic                  sys_clk,              // System clock
  input  wire logic                  rst_n,                // Async reset
  input  wire logic                  serial_clock_line,    // Bus clock
  input  wire logic                  sda_in,               // Bus data in
  input  wire logic [`STRAP_W-1:0]   mode_limit_strap_pin, // Strap code
  input  wire logic                  asleep,               // Sleep state
  input  wire logic [`ADDR_W-1:0]    own_addr,             // Our address
  output smbus_front_pkg::strap_cfg_t strap_cfg,           // Latched strap
  output logic                       cfg_valid,            // Strap latched
  output logic [`LIMIT_W-1:0]        hw_current_limit,     // Limit in mA
  output logic                       bus_enable,           // Serial ready
  output logic                       start_pulse,          // Start seen
  output logic                       addr_valid,           // Byte ready
  output smbus_front_pkg::addr_byte_t addr_info,           // First byte
  output logic                       wake_pulse,           // Wake began
  output logic                       discard_data,         // Waking access
  output logic                       scl_out,              // Clock drive
  output logic                       scl_oe                // Clock enable
);

  import smbus_front_pkg::*;

  // Map the low strap bits onto the eight limit steps
  function automatic logic [`LIMIT_W-1:0] limit_of
  (
    input logic [`STRAP_STEP_W-1:0] step
  );
    logic [`LIMIT_W-1:0] ma;
    ma = `LIM_500;
    unique case (step)
      3'h0: ma = `LIM_500;
      3'h1: ma = `LIM_900;
      3'h2: ma = `LIM_1000;
      3'h3: ma = `LIM_1200;
      3'h4: ma = `LIM_1500;
      3'h5: ma = `LIM_1800;
      3'h6: ma = `LIM_2000;
      3'h7: ma = `LIM_2500;
    endcase
    return ma;
  endfunction

  // ---------------- Link clock domain ----------------

  logic [`BYTE_W-1:0] link_shift;  // Bits taken on bus clock rises
  logic               link_tgl;    // Flips once per bus clock rise

  // Shift data on each bus clock rise; the toggle tells the
  // system side that a new bit sits in the shifter. The word is
  // stable for a whole clock low time, far longer than the sync.
  always_ff @(posedge serial_clock_line or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_shift <= '0;
      link_tgl   <= 1'b0;
    end
    else
    begin
      link_shift <= {link_shift[`BYTE_W-2:0], sda_in};
      link_tgl   <= ~link_tgl;
    end
  end

  // ---------------- System clock domain ----------------

  logic       scl_s1;   // Bus clock sync, first stage
  logic       scl_s2;   // Bus clock sync, second stage
  logic       scl_d;    // Bus clock, one cycle older
  logic       sda_s1;   // Bus data sync, first stage
  logic       sda_s2;   // Bus data sync, second stage
  logic       sda_d;    // Bus data, one cycle older
  logic       tgl_s1;   // Bit toggle sync, first stage
  logic       tgl_s2;   // Bit toggle sync, second stage
  logic       tgl_d;    // Bit toggle, one cycle older

  // Two-flop synchronisers; only the second stage and its one-cycle-older copy feed logic
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_d  <= 1'b0;
    end
    else
    begin
      scl_s1 <= serial_clock_line;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_d  <= tgl_s2;
    end
  end

  logic [`STRAP_W-1:0] strap_s1;  // Strap sync, first stage
  logic [`STRAP_W-1:0] strap_s2;  // Strap sync, second stage

  // The strap is a slow static level but still crosses in
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1 <= '0;
      strap_s2 <= '0;
    end
    else
    begin
      strap_s1 <= mode_limit_strap_pin;
      strap_s2 <= strap_s1;
    end
  end

  front_state_t            state;       // Sequencer state
  front_state_t            next_state;  // Sequencer next state
  logic [`TMR_W-1:0]       tmr;         // Quiet and wake timer
  logic                    in_frame;    // Between start and stop
  logic                    byte_done;   // Address byte taken
  logic [`BIT_CNT_W-1:0]   bit_cnt;     // Bits seen in this frame
  logic                    woke_frame;  // Frame did the waking

  // Decoded strap and bus events
  wire comm_mode_t strap_mode = comm_mode_t'(strap_s2[`STRAP_MODE_BIT]);
  wire [`LIMIT_W-1:0] strap_limit =
    limit_of(strap_s2[`STRAP_STEP_W-1:0]);
  wire start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire bit_edge   = tgl_s2 ^ tgl_d;
  // Listen only after the quiet time and only in serial mode
  wire listening  = (state != ST_QUIET) & cfg_valid &
                    (strap_cfg.mode == MODE_SERIAL);
  wire last_bit   = in_frame & ~byte_done & bit_edge &
                    (bit_cnt == `LAST_BIT);
  wire is_read    = (link_shift[`RW_BIT] == `RW_READ);
  wire our_read   = last_bit & is_read &
                    (link_shift[`BYTE_W-1:`ADDR_LSB] == own_addr);
  wire do_wake    = (state == ST_RUN) & asleep & our_read;
  wire quiet_end  = (state == ST_QUIET) & (tmr == QUIET_CYC - 1'b1);
  wire wake_end   = (state == ST_WAKE) & (tmr == WAKE_CYC - 1'b1);

  // Next state of the sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_QUIET:
      begin
        if (quiet_end)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (do_wake)
          next_state = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (wake_end)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_QUIET;  // Recover from a corrupt code
    endcase
  end

  // Sequencer state and its timer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_QUIET;
      tmr   <= '0;
    end
    else
    begin
      state <= next_state;
      if ((state != next_state) || (state == ST_RUN))
        tmr <= '0;
      else
        tmr <= tmr + 1'b1;
    end
  end

  // Latch the strap once, after the synchronisers have settled;
  // it is never taken again, so a later pin glitch changes nothing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_valid <= 1'b0;
      strap_cfg <= '0;
    end
    else if (!cfg_valid && (state == ST_QUIET) &&
             (tmr == `STRAP_LATCH_CYC))
    begin
      cfg_valid       <= 1'b1;
      strap_cfg.mode  <= strap_mode;
      strap_cfg.limit <= strap_limit;
    end
  end

  // Frame tracking: a start opens a frame and restarts the count,
  // a stop closes it. Repeated starts reopen cleanly.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_frame  <= 1'b0;
      byte_done <= 1'b0;
      bit_cnt   <= '0;
    end
    else if (start_seen && listening)
    begin
      in_frame  <= 1'b1;
      byte_done <= 1'b0;
      bit_cnt   <= '0;
    end
    else if (stop_seen || !listening)
    begin
      in_frame  <= 1'b0;  // Traffic ignored outside listening
      byte_done <= 1'b0;
      bit_cnt   <= '0;
    end
    else if (in_frame && !byte_done && bit_edge)
    begin
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == `LAST_BIT)
        byte_done <= 1'b1;
    end
  end

  // Hand out the first byte of each frame
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_valid <= 1'b0;
      addr_info  <= '0;
    end
    else
    begin
      addr_valid <= last_bit;
      if (last_bit)
      begin
        addr_info.addr <= link_shift[`BYTE_W-1:`ADDR_LSB];
        addr_info.rw   <= link_shift[`RW_BIT];
      end
    end
  end

  // Mark the waking access; the set wins over a stop in the same
  // cycle so a wake is never lost
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      woke_frame <= 1'b0;
    else if (do_wake)
      woke_frame <= 1'b1;
    else if (stop_seen || !listening)
      woke_frame <= 1'b0;
  end

  // Pulses and flags for the rest of the device
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_pulse <= 1'b0;
      wake_pulse  <= 1'b0;
    end
    else
    begin
      start_pulse <= start_seen & listening;
      wake_pulse  <= do_wake;
    end
  end

  // Data is junk while the waking access runs or the wake timer
  // counts; full service only in run state
  assign discard_data = woke_frame | (state == ST_WAKE);
  assign bus_enable   = listening & (state == ST_RUN);
  assign hw_current_limit = strap_cfg.limit;

  // This client never stretches the clock, so the clock driver
  // stays off; the host may stretch freely since the link logic
  // only reacts to edges
  assign scl_out = 1'b0;
  assign scl_oe  = 1'b0;

endmodule

// ==== testbench/smbus_front_props.sv ====
`timescale 1ns/10ps
`include "smbus_front_map.svh"
// Port-level watch on the mode select front end
module smbus_front_props
  import smbus_front_pkg::*;
#(
  parameter logic [`TMR_W-1:0] QUIET_CYC = 17'h00028, // Quiet cycles
  parameter logic [`TMR_W-1:0] WAKE_CYC  = 17'h00014  // Wake cycles
)
(
  input wire logic                  sys_clk,           // System clock
  input wire logic                  rst_n,             // Async reset
  input wire logic                  serial_clock_line, // Bus clock
  input wire logic                  sda_in,            // Bus data
  input smbus_front_pkg::strap_cfg_t strap_cfg,        // Latched strap
  input wire logic                  cfg_valid,         // Strap latched
  input wire logic [`LIMIT_W-1:0]   hw_current_limit,  // Limit in mA
  input wire logic                  bus_enable,        // Serial ready
  input wire logic                  start_pulse,       // Start seen
  input wire logic                  addr_valid,        // Byte ready
  input smbus_front_pkg::addr_byte_t addr_info,        // First byte
  input wire logic                  wake_pulse,        // Wake began
  input wire logic                  discard_data,      // Waking access
  input wire logic                  scl_out,           // Clock drive
  input wire logic                  scl_oe             // Clock enable
);
  // Wake window, one cycle of slack either side
  localparam int W_LO = int'(WAKE_CYC) - 1;
  localparam int W_HI = int'(WAKE_CYC) + 1;
  logic [`TMR_W-1:0] up_cnt; // Cycles since reset, saturating

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Saturates so a long run never wraps back into the quiet window
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      up_cnt <= '0;
    else if (up_cnt != '1)
      up_cnt <= up_cnt + 1'b1;

  property p_no_stretch;
    !scl_oe && !scl_out;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("clock line driven");
  property p_limit;
    hw_current_limit == strap_cfg.limit;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit differs from strap");
  property p_hold;
    cfg_valid && $past(cfg_valid) |-> $stable(strap_cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap changed after latch");
  property p_mode;
    bus_enable |-> cfg_valid && strap_cfg.mode == MODE_SERIAL;
  endproperty
  a_mode: assert property (p_mode)
    else $error("bus enabled outside serial mode");
  property p_quiet;
    bus_enable |-> up_cnt >= QUIET_CYC - 1'b1;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus enabled in quiet time");
  property p_wake;
    wake_pulse |-> addr_valid && addr_info.rw && !bus_enable && discard_data;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without a read");
  property p_wake_end;
    wake_pulse |-> ##[W_LO:W_HI] bus_enable;
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("wake time wrong");
  property p_wake_hold;
    wake_pulse |=> !bus_enable [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("bus back too early");
  property p_start;
    start_pulse |-> !$past(sda_in, 2) && $past(serial_clock_line, 2);
  endproperty
  a_start: assert property (p_start)
    else $error("start without data fall");
  property p_addr_hold;
    $changed(addr_info) |-> addr_valid;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("first byte changed alone");
endmodule

bind smbus_mode_select_front smbus_front_props
  #(.QUIET_CYC(QUIET_CYC), .WAKE_CYC(WAKE_CYC)) u_props
(
  .sys_clk(sys_clk), .rst_n(rst_n), .serial_clock_line(serial_clock_line),
  .sda_in(sda_in), .strap_cfg(strap_cfg), .cfg_valid(cfg_valid),
  .hw_current_limit(hw_current_limit), .bus_enable(bus_enable),
  .start_pulse(start_pulse), .addr_valid(addr_valid),
  .addr_info(addr_info), .wake_pulse(wake_pulse),
  .discard_data(discard_data), .scl_out(scl_out), .scl_oe(scl_oe)
);

// ==== testbench/i2c_host_model.sv ====
`timescale 1ns/10ps
// Bus host; drives both lines idle high, clock still between frames
module i2c_host_model
(
  output logic scl, // Bus clock
  output logic sda  // Bus data
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Half bus period on a 30 ns base; slow stretches it
  task automatic half(input int slow);
    #(30 * (15 + slow));
  endtask
  // Start, eight bits MSB first, released ninth bit, stop
  task automatic frame(input logic [7:0] b, input int slow);
    sda = 1'b0; // Data falls while clock high
    half(slow);
    for (int i = 8; i >= 0; i--)
    begin
      scl = 1'b0;
      #150 sda = (i > 0) ? b[i-1] : 1'b1; // Ninth bit released
      half(slow);
      scl = 1'b1;
      half(slow);
    end
    scl = 1'b0;
    #150 sda = 1'b0;
    half(slow);
    scl = 1'b1;
    half(slow);
    sda = 1'b1;
    half(slow);
  endtask
endmodule

// ==== testbench/tb_smbus_mode_select_front.sv ====
`timescale 1ns/10ps
`include "smbus_front_map.svh"
// Boots the block under every strap code and runs host frames at it
module tb_smbus_mode_select_front;
  import smbus_front_pkg::*;
  localparam logic [`TMR_W-1:0] QC = 17'h00190; // Short quiet time
  localparam logic [`TMR_W-1:0] WC = 17'h00064; // Outlasts a frame tail
  logic        sys_clk, rst_n, asleep;
  logic [3:0]  strap;         // Strap code
  logic [6:0]  own;           // Our address
  wire         scl, sda;      // Bus lines
  strap_cfg_t  cfg;           // Latched strap
  addr_byte_t  ainfo;         // First byte
  logic [11:0] lim;           // Current limit
  logic        cv, be, sp, av, wp, dd;
  int          n_fail, samples_checked, n_start, n_wake;
  int          seed = 33084;
  logic [7:0]  expq[$];       // Expected first bytes
  logic [11:0] ltab[8];       // Limit per step

  smbus_mode_select_front #(.QUIET_CYC(QC), .WAKE_CYC(WC)) u_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .serial_clock_line(scl),
    .sda_in(sda), .mode_limit_strap_pin(strap), .asleep(asleep),
    .own_addr(own), .strap_cfg(cfg), .cfg_valid(cv),
    .hw_current_limit(lim), .bus_enable(be), .start_pulse(sp),
    .addr_valid(av), .addr_info(ainfo), .wake_pulse(wp),
    .discard_data(dd), .scl_out(), .scl_oe()
  );
  i2c_host_model u_host (.scl(scl), .sda(sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Takes the oldest note whenever a first byte appears; looks on
  // the falling edge, where the registered pulses have settled
  always @(negedge sys_clk)
  begin
    if (sp)
      n_start++;
    if (wp)
      n_wake++;
    if (wp)
      check({15'h0, dd}, 16'h1);
    if (av && expq.size() == 0)
      check(16'h1, 16'h0);
    else if (av)
      check({8'h0, ainfo}, {8'h0, expq.pop_front()});
  end

  // Notes the byte only when the block must report it
  task automatic send(input logic [7:0] b, input bit heard, input int slow);
    if (heard)
      expq.push_back(b);
    // Bus edges at slow 0 fall on the clock grid; start off the sampling edge
    @(posedge sys_clk);
    #2 u_host.frame(b, slow);
    repeat (4) @(posedge sys_clk);
  endtask

  // Power cycle with one strap code, then one frame in the quiet time and one after it
  task automatic boot(input logic [3:0] code);
    @(posedge sys_clk) #2 rst_n = 1'b0;
    strap = code;
    repeat (8) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    #2 strap = 4'($random(seed)); // Later strap moves must be ignored
    check({15'h0, cv}, 16'h1);
    send(8'h5a, 1'b0, 0); // Frame in the quiet time
    check({15'h0, be}, 16'h0);
    repeat (QC) @(posedge sys_clk);
    check({3'h0, cfg}, {3'h0, code[3], ltab[code[2:0]]});
    check({4'h0, lim}, {4'h0, ltab[code[2:0]]});
    check({15'h0, be}, {15'h0, ~code[3]});
    n_start = 0;
    send(8'($random(seed)), ~code[3], 0);
    check(16'(n_start), {15'h0, ~code[3]});
  endtask

  initial
  begin
    rst_n = 1'b0;
    asleep = 1'b0;
    strap = 4'h0;
    own = 7'h2a;
    n_fail = 0;
    samples_checked = 0;
    n_wake = 0;
    ltab = '{`LIM_500, `LIM_900, `LIM_1000, `LIM_1200,
             `LIM_1500, `LIM_1800, `LIM_2000, `LIM_2500};
    for (int c = 0; c < 16; c++)
      boot(4'(c));
    boot(4'h2);
    own = 7'($random(seed));
    @(posedge sys_clk) #2 asleep = 1'b1;
    send({own, 1'b0}, 1'b1, 3); // Write while asleep, slow host clock
    send({~own, 1'b1}, 1'b1, 0); // Read to another address
    check(16'(n_wake), 16'h0);
    send({own, 1'b1}, 1'b1, 0); // Waking read
    check(16'(n_wake), 16'h1);
    check({15'h0, be}, 16'h0);
    @(posedge sys_clk) #2 asleep = 1'b0;
    repeat (WC) @(posedge sys_clk);
    check({15'h0, be}, 16'h1);
    send({own, 1'b1}, 1'b1, 0); // Access after the wait
    check(16'(n_wake), 16'h1);
    summarize();
  end

  // Run needs about 0.8 ms; a hang is cut off well past that
  initial
  begin
    #3000000;
    n_fail++;
    summarize();
  end
endmodule
